/* level_defines.svh */
// Holds the offsets, field positions, reset values and word addresses of the level unit.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef LEVEL_DEFINES_SVH
`define LEVEL_DEFINES_SVH

// ***************************************************************
// Register port offsets and fields
// ***************************************************************
`define REG_EVENT_STATUS   2'h0
`define REG_EVENT_MASK     2'h1
`define REG_LEVEL_STATE    2'h2
`define EVT_HONORED_BIT    0
`define EVT_RETIRED_BIT    1
`define STATE_REQ_BIT      7
`define STATE_INSVC_BIT    8
`define EVENT_RESET        2'h0
`define MASK_RESET         2'h0

// ***************************************************************
// Level count, word map and instruction layout
// ***************************************************************
`define LEVEL_COUNT        96
`define FIXED_LEVELS       2
`define FIXED_ENABLE       2'h3
`define POWER_FAIL_WORD    10'h200
`define STALL_ALARM_WORD   10'h201
`define FIRST_ORDINARY     10'h202
`define LOW_BANK_LEVELS    7'h30
`define CHANNEL_FIRST      10'h230
`define CHANNEL_LAST       10'h23F
`define CHANNEL_SKIP       10'h210
`define LAST_LEVEL_WORD    10'h26F
`define STORE_PLACE_BRANCH 4'hA
`define INDIRECT_FLAG      1'h1

`endif

/* level_types_pkg.sv */
// Holds the types and the level-to-word mapping shared by the level unit files.
// Assumes level_defines.svh is on the include path.
`include "level_defines.svh"

package level_types_pkg;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [0:0] {
    HONOR_IDLE = 1'b0,
    HONOR_SEND = 1'b1
  } honor_state_type;

  // Words 1000..1057 octal serve levels 0..47; the channel pointer words are skipped after it.
  // word map
  function automatic logic [9:0] level_word(input logic [6:0] idx);
    if (idx < `LOW_BANK_LEVELS) begin
      level_word = 10'(`POWER_FAIL_WORD + {3'h0, idx});
    end else begin
      level_word = 10'(`POWER_FAIL_WORD + `CHANNEL_SKIP - 10'h200 + {3'h0, idx});
    end
  endfunction

endpackage

/* level_priority_chain.sv */
// Holds the combinational priority chain across all levels.
// Assumes level 0 ranks highest and each higher index ranks lower.
`include "level_defines.svh"

module level_priority_chain (
  input  wire logic [95:0] req_state,     // Request latches.
  input  wire logic [95:0] enable_state,  // Enable latches.
  input  wire logic [95:0] insvc_state,   // In-service flip-flops.
  output logic      [95:0] present,       // One-hot presented request.
  output logic      [95:0] top_insvc      // One-hot highest routine in service.
);

  // ***************************************************************
  // Ripple of inhibit from higher levels
  // ***************************************************************
  // A ripple keeps the logic small; at 96 levels the depth is acceptable at 100 MHz.
  always_comb begin
    logic blocked;
    logic seen;
    blocked = 1'b0;
    seen    = 1'b0;
    for (int k = 0; k < `LEVEL_COUNT; k++) begin
      present[k]   = req_state[k] & enable_state[k] & ~insvc_state[k] & ~blocked;
      blocked      = blocked | (req_state[k] & enable_state[k]) | insvc_state[k];
      top_insvc[k] = insvc_state[k] & ~seen;
      seen         = seen | insvc_state[k];
    end
  end

endmodule

/* level_word_encoder.sv */
// Holds the unary-to-binary encoder and the branch instruction builder.
// Assumes at most one bit of the winner vector is set.
`include "level_defines.svh"

module level_word_encoder (
  input  wire logic [95:0] winner,       // One-hot winning level.
  output logic      [6:0]  winner_idx,   // Binary index of the winner.
  output logic      [15:0] instr_word    // Branch instruction for the winner.
);

  // ***************************************************************
  // Encoder
  // ***************************************************************
  // unary to binary
  always_comb begin
    winner_idx = 7'h00;
    for (int k = 0; k < `LEVEL_COUNT; k++) begin
      if (winner[k]) begin
        winner_idx = 7'(k);
      end
    end
  end

  assign instr_word = {`STORE_PLACE_BRANCH, `INDIRECT_FLAG, 1'h0,
                       level_types_pkg::level_word(winner_idx)};

endmodule

/* priority_interrupt_levels.sv */
// Holds the top of the 96-level priority interrupt unit with its latches and register port.
// Assumes all inputs but sys_rst are synchronous to sys_clk and strobes last one cycle.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`include "level_defines.svh"

module priority_interrupt_levels (
  input  wire logic        sys_clk,             // System clock, 100 MHz.
  input  wire logic        sys_rst,             // Asynchronous reset, active high.
  input  wire logic        intr_switch_on,      // Panel interrupt switch, high when on.
  input  wire logic        late_phase_a,        // Pulse opening the blocked phase window.
  input  wire logic        early_phase_b,       // Pulse closing the blocked phase window.
  input  wire logic [95:0] source_req,          // Interrupt source lines.
  input  wire logic        level_enable_instr,  // Enable instruction strobe.
  input  wire logic        level_disable_instr, // Disable instruction strobe.
  input  wire logic [95:0] level_select,        // Levels chosen by the instruction.
  input  wire logic        honor_strobe,        // Processor honors the request.
  input  wire logic        end_of_routine,      // Reset in-service command.
  input  wire logic [1:0]  reg_addr,            // Register address.
  input  wire logic [15:0] reg_wdata,           // Register write data.
  input  wire logic        reg_wr,              // Register write strobe.
  input  wire logic        reg_rd,              // Register read strobe.
  output logic      [15:0] reg_rdata,           // Read data, cycle after the strobe.
  output logic             cpu_request,         // ORed request to processor control.
  output logic      [15:0] mem_out_bus,         // Branch instruction to memory output bus.
  output logic             mem_out_valid,       // Instruction valid on the bus.
  output logic      [6:0]  winning_level,       // Index of the last honored level.
  output logic             irq                  // Level interrupt, unmasked event pending.
);

  // ***************************************************************
  // State
  // ***************************************************************
  logic [95:0] req_reg, req_next;
  logic [95:0] en_reg, en_next;
  logic [95:0] insvc_reg, insvc_next;
  logic        window_reg, window_next;
  logic        cpu_request_reg, cpu_request_next;
  logic [15:0] bus_reg, bus_next;
  logic [6:0]  win_reg, win_next;
  logic [1:0]  status_reg, status_next;
  logic [1:0]  mask_reg, mask_next;
  logic        irq_reg, irq_next;
  logic [15:0] rdata_reg, rdata_next;
  level_types_pkg::honor_state_type state_reg, state_next;

  logic [95:0] present;
  logic [95:0] top_insvc;
  logic [6:0]  win_idx;
  logic [15:0] instr_word;
  logic        set_blocked;
  logic        honor_take;
  logic        retire_take;
  logic [95:0] honor_set;
  logic [95:0] retire_clr;

  // ***************************************************************
  // Priority chain and encoder
  // ***************************************************************
  level_priority_chain chain_inst (
    .req_state    (req_reg),
    .enable_state (en_reg),
    .insvc_state  (insvc_reg),
    .present      (present),
    .top_insvc    (top_insvc)
  );

  level_word_encoder encoder_inst (
    .winner     (present),
    .winner_idx (win_idx),
    .instr_word (instr_word)
  );

  // ***************************************************************
  // Phase window and request latches
  // ***************************************************************
  // The window counts as blocked from the opening pulse through the closing pulse.
  always_comb begin
    window_next = window_reg;
    if (late_phase_a) begin
      window_next = 1'b1;
    end else if (early_phase_b) begin
      window_next = 1'b0;
    end
  end

  assign set_blocked = late_phase_a | window_reg;

  // Honor is taken on the live winner so the processor never waits for the output flop.
  // honor accepted
  assign honor_take  = (state_reg == level_types_pkg::HONOR_IDLE) & honor_strobe & (|present);
  assign retire_take = end_of_routine & (|insvc_reg);
  assign honor_set   = honor_take ? present : 96'h0;
  assign retire_clr  = end_of_routine ? top_insvc : 96'h0;

  // latch held
  // A new source event wins over a retire in the same cycle so it is not lost.
  always_comb begin
    req_next = (req_reg & ~retire_clr) | (set_blocked ? 96'h0 : source_req);
  end

  // ***************************************************************
  // Enable latches and in-service flip-flops
  // ***************************************************************
  always_comb begin
    en_next    = en_reg;
    insvc_next = insvc_reg;
    if (!intr_switch_on) begin
      en_next    = 96'h0;
      insvc_next = 96'h0;
    end else begin
      if (level_enable_instr) begin
        en_next = en_reg | level_select;
      end else if (level_disable_instr) begin
        en_next = en_reg & ~level_select;
      end
      insvc_next = (insvc_reg & ~retire_clr) | honor_set;
    end
    en_next[`FIXED_LEVELS-1:0] = `FIXED_ENABLE;
  end

  // ***************************************************************
  // Honor sequence
  // ***************************************************************
  // The bus word stands one cycle; a second honor during it is ignored.
  always_comb begin
    state_next = state_reg;
    bus_next   = 16'h0000;
    win_next   = win_reg;
    case (state_reg)
      level_types_pkg::HONOR_IDLE: begin
        if (honor_take) begin
          bus_next   = instr_word;
          win_next   = win_idx;
          state_next = level_types_pkg::HONOR_SEND;
        end
      end
      level_types_pkg::HONOR_SEND: begin
        state_next = level_types_pkg::HONOR_IDLE;
      end
      default: begin
        state_next = level_types_pkg::HONOR_IDLE;
      end
    endcase
  end

  assign cpu_request_next = |present;

  // ***************************************************************
  // Event status, mask and register port
  // ***************************************************************
  // Status bits are write-one-to-clear; a new event in the clearing cycle is kept.
  always_comb begin
    logic [1:0] clr;
    logic [1:0] evt;
    clr = (reg_wr && reg_addr == `REG_EVENT_STATUS) ? reg_wdata[1:0] : 2'h0;
    evt = 2'h0;
    evt[`EVT_HONORED_BIT] = honor_take;
    evt[`EVT_RETIRED_BIT] = retire_take;
    status_next = (status_reg & ~clr) | evt;
    mask_next   = (reg_wr && reg_addr == `REG_EVENT_MASK) ? reg_wdata[1:0] : mask_reg;
    irq_next    = |(status_next & mask_next);
  end

  // Unmapped addresses and idle cycles read as zero.
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_EVENT_STATUS: rdata_next = {14'h0, status_reg};
        `REG_EVENT_MASK:   rdata_next = {14'h0, mask_reg};
        `REG_LEVEL_STATE:  rdata_next = {7'h0, |insvc_reg, cpu_request_reg, win_reg};
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_reg         <= 96'h0;
      en_reg          <= {94'h0, `FIXED_ENABLE};
      insvc_reg       <= 96'h0;
      window_reg      <= 1'b0;
      cpu_request_reg <= 1'b0;
      bus_reg         <= 16'h0000;
      win_reg         <= 7'h00;
      status_reg      <= `EVENT_RESET;
      mask_reg        <= `MASK_RESET;
      irq_reg         <= 1'b0;
      rdata_reg       <= 16'h0000;
      state_reg       <= level_types_pkg::HONOR_IDLE;
    end else begin
      req_reg         <= req_next;
      en_reg          <= en_next;
      insvc_reg       <= insvc_next;
      window_reg      <= window_next;
      cpu_request_reg <= cpu_request_next;
      bus_reg         <= bus_next;
      win_reg         <= win_next;
      status_reg      <= status_next;
      mask_reg        <= mask_next;
      irq_reg         <= irq_next;
      rdata_reg       <= rdata_next;
      state_reg       <= state_next;
    end
  end

  assign reg_rdata     = rdata_reg;
  assign cpu_request   = cpu_request_reg;
  assign mem_out_bus   = bus_reg;
  assign mem_out_valid = (state_reg == level_types_pkg::HONOR_SEND);
  assign winning_level = win_reg;
  assign irq           = irq_reg;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // Switch off clears the ordinary-level enables and all in-service flip-flops on the next edge.
  a_switch_hold_clear: assert property (
    !intr_switch_on |=> (en_reg[95:2] == 94'h0) && (insvc_reg == 96'h0))
    else $error("enable or in-service survived switch off");

  // Fixed levels never lose their enable.
  a_fixed_level_enabled: assert property (
    en_reg[1:0] == 2'h3)
    else $error("fixed level lost its enable");

  // Enable and disable strobes touch only the selected levels.
  a_enable_sets_selected: assert property (
    intr_switch_on && level_enable_instr
    |=> ((en_reg & $past(level_select)) == $past(level_select)))
    else $error("selected level not enabled");

  a_enable_keeps_others: assert property (
    intr_switch_on && level_enable_instr
    |=> ((en_reg & ~$past(level_select)) == ($past(en_reg) & ~$past(level_select))))
    else $error("unselected enable changed");

  a_disable_clears_sel: assert property (
    intr_switch_on && level_disable_instr && !level_enable_instr
    |=> ((en_reg[95:2] & $past(level_select[95:2])) == 94'h0))
    else $error("selected level still enabled after disable");

  // Sources are ignored inside the blocked phase window and latched outside it.
  a_window_no_set: assert property (
    (late_phase_a || window_reg) |=> ((req_reg & ~$past(req_reg)) == 96'h0))
    else $error("request latched inside the phase window");

  a_source_latches: assert property (
    !late_phase_a && !window_reg |=> ((req_reg & $past(source_req)) == $past(source_req)))
    else $error("source outside window not latched");

  // Presentation and the ORed request to the processor.
  a_request_is_or: assert property (
    ##1 cpu_request == $past(|present))
    else $error("processor request is not the OR of presented levels");

  a_one_presented: assert property (
    $onehot0(present))
    else $error("more than one level presented");

  a_present_gated: assert property (
    (present & ~(req_reg & en_reg)) == 96'h0)
    else $error("level presented without request and enable");

  a_insvc_no_present: assert property (
    (present & insvc_reg) == 96'h0)
    else $error("in-service level still presented");

  // Honor, instruction word and word map.
  a_honor_sets_insvc: assert property (
    honor_take && intr_switch_on |=> insvc_reg[$past(win_idx)])
    else $error("honored level not in service");

  a_honor_bus_word: assert property (
    honor_take |=> mem_out_valid && (mem_out_bus[15:12] == 4'hA)
    && (mem_out_bus[9:0] == level_types_pkg::level_word($past(win_idx))) ##1 !mem_out_valid)
    else $error("branch instruction missing or wrong");

  a_word_first_level: assert property (
    honor_take && present[2] |=> mem_out_bus[9:0] == 10'h202)
    else $error("first ordinary level has wrong word");

  a_word_power_fail: assert property (
    honor_take && present[0] |=> mem_out_bus[9:0] == 10'h200)
    else $error("power-fail level has wrong word");

  a_word_channel_gap: assert property (
    mem_out_valid |-> !((mem_out_bus[9:0] >= 10'h230) && (mem_out_bus[9:0] <= 10'h23F))
    && (mem_out_bus[9:0] <= 10'h26F))
    else $error("level word inside channel pointer area");

  // Retire of the highest routine and requests held behind it.
  a_retire_highest: assert property (
    intr_switch_on && end_of_routine && !honor_take
    |=> insvc_reg == ($past(insvc_reg) & ~$past(top_insvc)))
    else $error("retire did not clear exactly the highest routine");

  a_blocked_stays: assert property (
    req_reg[5] && (|insvc_reg[4:0]) && !(end_of_routine && top_insvc[5]) |=> req_reg[5])
    else $error("blocked request was lost");

  c_honor_seen: cover property (honor_take ##1 mem_out_valid);
  c_nested: cover property (honor_take ##[1:20] honor_take);
  c_retire_seen: cover property (retire_take && (insvc_reg != top_insvc));
  c_irq_raised: cover property (!irq ##1 irq);
  // A source that arrives inside the blocked window.
  c_window_blocked: cover property (window_reg && (|source_req));

endmodule

/* mainframe_model.sv */
// Holds a behavioural model of the mainframe timing and control logic.
// Assumes it shares sys_clk and sys_rst with the level unit it serves.

module mainframe_model (
  input  wire logic        sys_clk,       // System clock.
  input  wire logic        sys_rst,       // Asynchronous reset, active high.
  input  wire logic        cpu_request,   // ORed request from the unit.
  input  wire logic        mem_out_valid, // Instruction valid on the bus.
  input  wire logic [15:0] mem_out_bus,   // Branch instruction from the unit.
  input  wire logic        phase_go,      // Bench asks for one blocked window.
  output logic             late_phase_a,  // Opens the blocked window.
  output logic             early_phase_b, // Closes the blocked window.
  output logic             honor_strobe,  // Honors the current request.
  output logic      [15:0] taken_word     // Last instruction executed.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_cnt;

  // ***************************************************************
  // Phases, honor and execution
  // ***************************************************************
  // The honor waits out its own strobe and the answer, so honors stay three cycles apart.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      late_phase_a <= 1'b0;
      early_phase_b <= 1'b0;
      phase_cnt <= 3'h0;
      honor_strobe <= 1'b0;
      taken_word <= 16'h0000;
    end else begin
      late_phase_a <= phase_go;
      phase_cnt <= phase_go ? 3'h3 : ((phase_cnt != 3'h0) ? phase_cnt - 3'h1 : 3'h0);
      early_phase_b <= (phase_cnt == 3'h1);
      honor_strobe <= cpu_request && !honor_strobe && !mem_out_valid;
      if (mem_out_valid) begin
        taken_word <= mem_out_bus;
      end
    end
  end
endmodule

/* priority_interrupt_levels_tb.sv */
// Holds the self-checking bench of the priority interrupt level unit.
// Assumes mainframe_model answers every request and makes the phase window.
`include "level_defines.svh"

module priority_interrupt_levels_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, sys_rst, intr_switch_on, late_phase_a, early_phase_b, phase_go;
  logic        level_enable_instr, level_disable_instr, honor_strobe, end_of_routine;
  logic        reg_wr, reg_rd, cpu_request, mem_out_valid, irq;
  logic [95:0] source_req, level_select;
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, mem_out_bus, taken_word;
  logic [6:0]  winning_level;
  logic [6:0]  map_idx [9];
  int          bad_count, checks;

  priority_interrupt_levels i_priority_interrupt_levels (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .intr_switch_on(intr_switch_on), .late_phase_a(late_phase_a),
    .early_phase_b(early_phase_b), .source_req(source_req),
    .level_enable_instr(level_enable_instr), .level_disable_instr(level_disable_instr),
    .level_select(level_select), .honor_strobe(honor_strobe),
    .end_of_routine(end_of_routine), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_request(cpu_request),
    .mem_out_bus(mem_out_bus), .mem_out_valid(mem_out_valid),
    .winning_level(winning_level), .irq(irq));

  mainframe_model i_mainframe_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cpu_request(cpu_request), .mem_out_valid(mem_out_valid), .mem_out_bus(mem_out_bus),
    .phase_go(phase_go), .late_phase_a(late_phase_a), .early_phase_b(early_phase_b),
    .honor_strobe(honor_strobe), .taken_word(taken_word));

  // ***************************************************************
  // Tasks
  // ***************************************************************
  // Clock at 100 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run.
  task automatic conclude();
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Branch word a level must produce: levels 48 and up skip the channel words.
  function automatic logic [15:0] exp_instr(input logic [6:0] idx);
    logic [9:0] w;
    w = (idx < 7'h30) ? 10'h200 + {3'h0, idx} : 10'h240 + {3'h0, idx} - 10'h030;
    return {`STORE_PLACE_BRANCH, `INDIRECT_FLAG, 1'b0, w};
  endfunction

  // Every task starts and ends at a rising edge, so strobes never toggle twice at once.
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Reads one register and compares the word in the cycle after the strobe.
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
    @(posedge sys_clk);
  endtask

  // Enables or disables one level.
  task automatic sel(input logic [6:0] idx, input logic on);
    level_select <= 96'h1 << idx;
    level_enable_instr <= on;
    level_disable_instr <= ~on;
    @(posedge sys_clk);
    level_enable_instr <= 1'b0;
    level_disable_instr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // One-cycle pulse on a set of sources.
  task automatic pulse(input logic [95:0] v);
    source_req <= v;
    @(posedge sys_clk);
    source_req <= 96'h0;
    @(posedge sys_clk);
  endtask

  // End-of-routine command.
  task automatic eor();
    end_of_routine <= 1'b1;
    @(posedge sys_clk);
    end_of_routine <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Waits for the honored instruction and checks it in its only cycle.
  task automatic serve(input logic [6:0] idx);
    int n;
    for (n = 0; n < 30 && mem_out_valid !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 30) begin
      chk("mem_out_valid", 16'h0001, {15'h0, mem_out_valid});
      conclude();
    end else begin
      chk("mem_out_bus", exp_instr(idx), mem_out_bus);
      chk("winning_level", {9'h0, idx}, {9'h0, winning_level});
      @(posedge sys_clk);
    end
  endtask

  // Checks that no request reaches the processor for n cycles.
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1 chk("cpu_request", 16'h0000, {15'h0, cpu_request});
    end
    @(posedge sys_clk);
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  // Levels around every boundary of the word map, highest and lowest included.
  initial begin
    map_idx = '{7'h00, 7'h01, 7'h02, 7'h0D, 7'h0E, 7'h2F, 7'h30, 7'h31, 7'h5F};
    {sys_rst, intr_switch_on, phase_go, level_enable_instr, level_disable_instr} = 5'h10;
    {end_of_routine, reg_wr, reg_rd, reg_addr, reg_wdata} = 21'h0;
    {source_req, level_select} = 192'h0;
    bad_count = 0;
    checks = 0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    intr_switch_on <= 1'b1;
    rd(`REG_LEVEL_STATE, 16'h0000);
    wr(`REG_EVENT_MASK, 16'h0001);
    pulse(96'h1);
    serve(7'h00);
    #1 chk("irq", 16'h0001, {15'h0, irq});
    @(posedge sys_clk);
    rd(`REG_EVENT_STATUS, 16'h0001);
    eor();
    rd(`REG_EVENT_STATUS, 16'h0003);
    wr(`REG_EVENT_STATUS, 16'h0001);
    rd(`REG_EVENT_STATUS, 16'h0002);
    #1 chk("irq", 16'h0000, {15'h0, irq});
    @(posedge sys_clk);
    wr(`REG_EVENT_MASK, 16'h0000);
    wr(`REG_EVENT_STATUS, 16'h0002);
    rd(`REG_EVENT_STATUS, 16'h0000);
    rd(2'h3, 16'h0000);
    // Each mapped level alone, through its own fixed word.
    foreach (map_idx[k]) begin
      sel(map_idx[k], 1'b1);
      pulse(96'h1 << map_idx[k]);
      serve(map_idx[k]);
      eor();
    end
    rd(`REG_LEVEL_STATE, 16'h005F);
    sel(7'h09, 1'b1);
    sel(7'h14, 1'b1);
    sel(7'h03, 1'b1);
    sel(7'h05, 1'b1);
    sel(7'h05, 1'b0);
    pulse((96'h1 << 5) | (96'h1 << 9) | (96'h1 << 20));
    serve(7'h09);
    rd(`REG_LEVEL_STATE, 16'h0109);
    quiet(4);
    eor();
    serve(7'h14);
    pulse(96'h1 << 3);
    serve(7'h03);
    eor();
    rd(`REG_LEVEL_STATE, 16'h0103);
    eor();
    rd(`REG_LEVEL_STATE, 16'h0003);
    sel(7'h05, 1'b1);
    serve(7'h05);
    eor();
    // Source inside the blocked phase window, then outside it.
    sel(7'h28, 1'b1);
    phase_go <= 1'b1;
    @(posedge sys_clk);
    phase_go <= 1'b0;
    @(posedge sys_clk);
    pulse(96'h1 << 40);
    quiet(5);
    pulse(96'h1 << 40);
    serve(7'h28);
    eor();
    chk("taken_word", exp_instr(7'h28), taken_word);
    // Switch off clears the enable of an ordinary level.
    sel(7'h1E, 1'b1);
    intr_switch_on <= 1'b0;
    repeat (2) @(posedge sys_clk);
    intr_switch_on <= 1'b1;
    @(posedge sys_clk);
    pulse(96'h1 << 30);
    quiet(4);
    conclude();
  end
endmodule
